// >>> rtl/button_algo_config_regs.sv
// button algorithm configuration bytes and the per-channel controls they steer
module button_algo_config_regs
    import button_cfg_pkg::*;
(
    input  wire logic               i_sys_clk,
    input  wire logic               i_nrst,
    input  wire logic               i_wr_en,
    input  wire logic               i_rd_en,
    input  wire logic [ADDR_W-1:0]  i_addr,
    input  wire logic [DATA_W-1:0]  i_wdata,
    input  wire logic               i_lowpwr_mode,
    input  wire logic [NUM_CH-1:0]  i_button_output,
    output logic      [DATA_W-1:0]  o_rdata,
    output logic                    o_rd_valid,
    output logic      [2:0]         o_active_track_step,
    output logic      [2:0]         o_lowpwr_track_step,
    output logic      [2:0]         o_normpwr_track_step,
    output logic      [5:0]         o_ch3_sensitivity,
    output logic      [NUM_CH-1:0]  o_track_enable,
    output logic      [NUM_CH-1:0]  o_strongest_group,
    output logic      [2:0]         o_resonator_div_sel
);
    logic               rst_meta_reg;
    logic               rst_sync_reg;
    logic [DATA_W-1:0]  reg_val [NUM_REGS];
    logic [NUM_REGS-1:0] wr_sel;
    logic [DATA_W-1:0]  rdata_reg;
    logic [DATA_W-1:0]  rdata_next;
    logic               rd_valid_reg;
    logic               rd_valid_next;
    logic [2:0]         step_reg;
    logic [2:0]         step_next;
    logic [NUM_CH-1:0]  track_en_reg;
    logic [NUM_CH-1:0]  track_en_next;
    logic [7:0]         pause_group;

    localparam logic [7:0] RESETS [NUM_REGS] = '{RST_LP_STEP, RST_CH3_GAIN,
        RST_NP_STEP, RST_PAUSE_GROUP, RST_LC_DIV};

    // map an offset to a byte index; hit is low for unmapped offsets
    function automatic logic [IDX_W:0] decode(input logic [7:0] a);
        case (a)
            OFF_LP_STEP:     decode = {1'b1, IDX_LP};     // [RULE_02]
            OFF_CH3_GAIN:    decode = {1'b1, IDX_GAIN};
            OFF_NP_STEP:     decode = {1'b1, IDX_NP};     // [RULE_04]
            OFF_PAUSE_GROUP: decode = {1'b1, IDX_PAUSE};  // [RULE_13]
            OFF_LC_DIV:      decode = {1'b1, IDX_DIV};    // [RULE_14]
            default:         decode = '0;
        endcase
    endfunction

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // one storage cell per register, each with its own reset value
    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : g_cell
            logic [IDX_W:0] hit;
            assign hit = decode(i_addr);
            assign wr_sel[g] = i_wr_en && hit[IDX_W]
                && (hit[IDX_W-1:0] == IDX_W'(g));
            cfg_reg_cell #(
                .RESET_VAL (RESETS[g])                 // [RULE_13] [RULE_14]
            ) u_cell (
                .i_sys_clk (i_sys_clk),
                .i_rst_n   (rst_sync_reg),
                .i_wr      (wr_sel[g]),
                .i_wdata   (i_wdata & MASK_STEP),
                .o_value   (reg_val[g])
            );
        end
    endgenerate

    assign pause_group = reg_val[IDX_PAUSE];

    // read port: data one cycle after the strobe, zero when unmapped
    always_comb begin
        logic [IDX_W:0] rh;
        rh = decode(i_addr);
        rdata_next = rdata_reg;
        rd_valid_next = i_rd_en;
        if (i_rd_en) begin
            if (rh[IDX_W]) begin
                rdata_next = reg_val[rh[IDX_W-1:0]];
            end else begin
                rdata_next = READ_UNMAPPED;
            end
        end
    end

    // pick one step by the active power mode; pause while button asserted and its hold bit set
    always_comb begin
        if (power_mode_type'(i_lowpwr_mode) == MODE_LOWPWR) begin
            step_next = reg_val[IDX_LP][STEP_MSB:0];    // [RULE_01] [RULE_15]
        end else begin
            step_next = reg_val[IDX_NP][STEP_MSB:0];    // [RULE_04] [RULE_15]
        end
        for (int c = 0; c < NUM_CH; c++) begin
            // [RULE_05] [RULE_06] [RULE_07] [RULE_08]
            track_en_next[c] = !(pause_group[HOLD_LSB + c]
                && i_button_output[c]);
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            rdata_reg    <= '0;
            rd_valid_reg <= 1'b0;
            step_reg     <= '0;
            track_en_reg <= '1;
        end else begin
            rdata_reg    <= rdata_next;
            rd_valid_reg <= rd_valid_next;
            step_reg     <= step_next;
            track_en_reg <= track_en_next;
        end
    end

    // outputs; read port, active step and track enable come from flops, the other fields straight from the stored bytes
    assign o_rdata              = rdata_reg;
    assign o_rd_valid           = rd_valid_reg;
    assign o_active_track_step  = step_reg;
    assign o_lowpwr_track_step  = reg_val[IDX_LP][STEP_MSB:0];  // [RULE_01]
    assign o_normpwr_track_step = reg_val[IDX_NP][STEP_MSB:0];  // [RULE_04]
    assign o_ch3_sensitivity    = reg_val[IDX_GAIN][GAIN_MSB:0]; // [RULE_03]
    assign o_track_enable       = track_en_reg;
    // [RULE_09] [RULE_10] [RULE_11] [RULE_12]
    assign o_strongest_group    = pause_group[GROUP_LSB +: NUM_CH];
    assign o_resonator_div_sel  = reg_val[IDX_DIV][DIV_MSB:0];
endmodule // button_algo_config_regs

// >>> shared/button_cfg_pkg.sv
// constants for the button algorithm configuration register slice
// Summary of operation
// RULE_01: low power step in bits 2-0, reset 5
// RULE_02: low power step register at 13h, reset 05h
// RULE_03: channel 3 gain bits 5-0, reset 28h
// RULE_04: normal power step bits 2-0, 15h, reset 03h
// RULE_05: bit 7 holds channel 3 tracking while pressed
// RULE_06: bit 6 holds channel 2 tracking while pressed
// RULE_07: bit 5 holds channel 1 tracking while pressed
// RULE_08: bit 4 holds channel 0 tracking while pressed
// RULE_09: bit 3 puts channel 3 in strongest group
// RULE_10: bit 2 puts channel 2 in strongest group
// RULE_11: bit 1 puts channel 1 in strongest group
// RULE_12: bit 0 puts channel 0 in strongest group
// RULE_13: pause and group register at 16h, reset 00h
// RULE_14: resonator divider register at 17h, reset 03h
// RULE_15: active power mode picks exactly one step
package button_cfg_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          NUM_CH          = 4;
    localparam int          NUM_REGS        = 5;
    localparam int          IDX_W           = 3;
    localparam logic [7:0]  OFF_LP_STEP     = 8'h13;
    localparam logic [7:0]  OFF_CH3_GAIN    = 8'h14;
    localparam logic [7:0]  OFF_NP_STEP     = 8'h15;
    localparam logic [7:0]  OFF_PAUSE_GROUP = 8'h16;
    localparam logic [7:0]  OFF_LC_DIV      = 8'h17;
    localparam logic [7:0]  RST_LP_STEP     = 8'h05;
    localparam logic [7:0]  RST_CH3_GAIN    = 8'h28;
    localparam logic [7:0]  RST_NP_STEP     = 8'h03;
    localparam logic [7:0]  RST_PAUSE_GROUP = 8'h00;
    localparam logic [7:0]  RST_LC_DIV      = 8'h03;
    // writable bits; reserved bits are written and stored as well
    localparam logic [7:0]  MASK_STEP       = 8'hff;
    localparam int          STEP_MSB        = 2;
    localparam int          GAIN_MSB        = 5;
    localparam int          DIV_MSB         = 2;
    localparam int          HOLD_LSB        = 4;
    localparam int          GROUP_LSB       = 0;
    localparam logic [7:0]  READ_UNMAPPED   = 8'h00;
    typedef enum logic [2:0] {
        IDX_LP    = 3'b000,
        IDX_GAIN  = 3'b001,
        IDX_NP    = 3'b010,
        IDX_PAUSE = 3'b011,
        IDX_DIV   = 3'b100
    } reg_idx_type;
    typedef enum logic [0:0] {
        MODE_NORMAL = 1'b0,
        MODE_LOWPWR = 1'b1
    } power_mode_type;
endpackage

// >>> rtl/cfg_reg_cell.sv
// one resettable configuration byte with write strobe
module cfg_reg_cell
    import button_cfg_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_value
);
    logic [7:0] value_reg;
    logic [7:0] value_next;

    // hold unless this byte is addressed by a write
    always_comb begin
        value_next = i_wr ? i_wdata : value_reg;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            value_reg <= RESET_VAL;
        end else begin
            value_reg <= value_next;
        end
    end

    assign o_value = value_reg;
endmodule // cfg_reg_cell

// >>> sim/host_model.sv
// host side model issuing register writes and reads
module host_model (
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rd_valid,
    output logic            o_wr_en = 1'b0,
    output logic            o_rd_en = 1'b0,
    output logic      [7:0] o_addr = 8'h00,
    output logic      [7:0] o_wdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // released lines show inverted data so stale values never look valid
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_sys_clk);
        {o_wr_en, o_addr, o_wdata} <= {1'b1, a, v};
        @(posedge i_sys_clk);
        {o_wr_en, o_addr, o_wdata} <= {1'b0, ~a, ~v};
    endtask
    // answer is taken one cycle after the strobe, only when flagged valid
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_sys_clk);
        {o_rd_en, o_addr} <= {1'b1, a};
        @(posedge i_sys_clk);
        {o_rd_en, o_addr} <= {1'b0, ~a};
        #1 v = i_rd_valid ? i_rdata : 8'hxx;
    endtask
endmodule // host_model

// >>> sim/button_algo_config_regs_props.sv
// concurrent checks on the configuration register slice ports
module button_algo_config_regs_props (
    input wire logic       i_sys_clk,
    input wire logic       i_nrst,
    input wire logic       i_wr_en,
    input wire logic       i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_lowpwr_mode,
    input wire logic [3:0] i_button_output,
    input wire logic [7:0] o_rdata,
    input wire logic [2:0] o_active_track_step,
    input wire logic [2:0] o_lowpwr_track_step,
    input wire logic [2:0] o_normpwr_track_step,
    input wire logic [5:0] o_ch3_sensitivity,
    input wire logic [3:0] o_track_enable,
    input wire logic [3:0] o_strongest_group,
    input wire logic [2:0] o_resonator_div_sel
);
    logic [1:0] up_reg, up_next;
    logic [7:0] pg_reg, pg_next;
    logic       ok;
    // shadow of the pause byte; ok waits out the reset synchroniser
    always_comb begin
        up_next = up_reg + {1'b0, up_reg != 2'd3};
        pg_next = (i_wr_en && i_addr == 8'h16) ? i_wdata : pg_reg;
    end
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) {up_reg, pg_reg} <= 10'h000;
        else {up_reg, pg_reg} <= {up_next, pg_next};
    end
    assign ok = (up_reg == 2'd3);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    a_lp_step_wr: assert property (ok && i_wr_en && i_addr == 8'h13 |=>
        {5'h00, o_lowpwr_track_step} == ($past(i_wdata) & 8'h07)) else $error("lp step");
    a_gain_wr: assert property (ok && i_wr_en && i_addr == 8'h14 |=>
        {2'h0, o_ch3_sensitivity} == ($past(i_wdata) & 8'h3f)) else $error("gain");
    a_np_step_wr: assert property (ok && i_wr_en && i_addr == 8'h15 |=>
        {5'h00, o_normpwr_track_step} == ($past(i_wdata) & 8'h07)) else $error("np step");
    a_group_wr: assert property (ok |-> o_strongest_group == pg_reg[3:0])
        else $error("group bits");
    a_div_wr: assert property (ok && i_wr_en && i_addr == 8'h17 |=>
        {5'h00, o_resonator_div_sel} == ($past(i_wdata) & 8'h07)) else $error("div");
    a_step_pick: assert property (ok |-> o_active_track_step == ($past(i_lowpwr_mode)
        ? $past(o_lowpwr_track_step) : $past(o_normpwr_track_step))) else $error("step pick");
    a_track_gate: assert property (ok |-> o_track_enable ==
        ~($past(pg_reg[7:4]) & $past(i_button_output))) else $error("track gate");
    a_pause_read: assert property (ok && i_rd_en && i_addr == 8'h16 |=>
        o_rdata == $past(pg_reg)) else $error("pause read");
    c_lowpwr: cover property (ok && i_lowpwr_mode);
    c_hold: cover property (ok && o_track_enable != 4'hf);
    c_unmapped: cover property (ok && i_rd_en && i_addr == 8'h12);
endmodule // button_algo_config_regs_props
bind button_algo_config_regs button_algo_config_regs_props props_u (.*);

// >>> sim/button_algo_config_regs_tb.sv
// register read/write bench for the button configuration slice
module button_algo_config_regs_tb import button_cfg_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_lowpwr_mode = 1'b0;
    logic [3:0] i_button_output = 4'h0;
    logic i_wr_en, i_rd_en, o_rd_valid;
    logic [7:0] i_addr, i_wdata, o_rdata, d;
    logic [2:0] o_active_track_step, o_lowpwr_track_step;
    logic [2:0] o_normpwr_track_step, o_resonator_div_sel;
    logic [5:0] o_ch3_sensitivity;
    logic [3:0] o_track_enable, o_strongest_group;
    int err_total = 0, checked = 0, cyc = 0;
    logic [7:0] rst_tab [5] = '{8'h05, 8'h28, 8'h03, 8'h00, 8'h03};
    always #2 i_sys_clk = ~i_sys_clk;
    host_model host_u (.i_sys_clk(i_sys_clk), .i_rdata(o_rdata),
        .i_rd_valid(o_rd_valid), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
        .o_addr(i_addr), .o_wdata(i_wdata));
    button_algo_config_regs dut_u (.*);
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // a hang ends the run well past the expected seventy or so cycles
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            results;
        end
    end
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        for (int k = 0; k < 5; k++) begin
            host_u.rd(8'h13 + 8'(k), d);
            chk(d, rst_tab[k]);
        end
        $display("test defaults done");
        // all eight bits of every byte are kept, reserved ones too
        for (int k = 0; k < 5; k++) host_u.wr(8'h13 + 8'(k), 8'hc9 + 8'(k * 17));
        for (int k = 0; k < 5; k++) begin
            host_u.rd(8'h13 + 8'(k), d);
            chk(d, 8'hc9 + 8'(k * 17));
        end
        chk({o_ch3_sensitivity, o_lowpwr_track_step[1:0]}, 8'h69);
        chk({o_normpwr_track_step, o_resonator_div_sel, 2'b00}, 8'h74);
        host_u.wr(8'h12, 8'h77);
        host_u.rd(8'h12, d);
        chk(d, 8'h00);
        $display("test readback done");
        @(posedge i_sys_clk) i_lowpwr_mode <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        #1 chk(8'(o_active_track_step), 8'h01);
        @(posedge i_sys_clk) i_lowpwr_mode <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1 chk(8'(o_active_track_step), 8'h03);
        $display("test mode select done");
        for (int c = 0; c < 4; c++) begin
            host_u.wr(8'h16, (8'h11 << c));
            @(posedge i_sys_clk) i_button_output <= 4'hf;
            repeat (2) @(posedge i_sys_clk);
            #1 chk({o_track_enable, o_strongest_group}, {~(4'h1 << c), 4'h1 << c});
        end
        $display("test holds done");
        results;
    end
endmodule // button_algo_config_regs_tb
